// ===== aisf_pkg.sv
package aisf_pkg;
    localparam logic [7:0] ctrl_ofs      = 8'h00;
    localparam logic [7:0] status_ofs    = 8'h04;
    localparam logic [7:0] rate_ofs      = 8'h08;
    localparam logic [7:0] remote_ofs    = 8'h0c;
    localparam logic [7:0] remote_in_ofs = 8'h10;

    localparam logic [1:0] rate_sel_32  = 2'h0;
    localparam logic [1:0] rate_sel_48  = 2'h1;
    localparam logic [1:0] rate_sel_dig = 2'h2;
    localparam logic [1:0] rate_sel_rst = 2'h1;

    localparam int rate_32_hz = 32000;
    localparam int rate_48_hz = 48000;
    localparam int rate_mid_hz = (rate_32_hz + rate_48_hz) / 2;
    localparam int clk_hz = 50_000_000;
    // link clock rate: a frame period in link cycles divides this to give hz
    localparam int link_hz = 166_666_667;

    localparam int ctrl_rate_lsb  = 0;
    localparam int ctrl_fb_bit    = 2;
    localparam int ctrl_inline    = 3;
    localparam int ctrl_att_lsb   = 8;
    localparam int att_w          = 6;

    localparam int status_lock    = 0;
    localparam int status_fb      = 1;
    localparam int status_mute    = 2;
    localparam int status_flash   = 3;
    localparam int status_seen    = 4;
    localparam int status_hi      = 5;

    localparam int flash_half_ms  = 250;
    localparam int flash_cycles   = clk_hz / 1000 * flash_half_ms;

    localparam int n_rin  = 7;
    localparam int n_rout = 4;
    localparam int osel_w = 4;

    localparam logic [3:0] osel_off    = 4'h0;
    localparam logic [3:0] osel_on     = 4'h1;
    localparam logic [3:0] osel_bypass = 4'h2;
    localparam logic [3:0] osel_unlock = 4'h3;
    localparam logic [3:0] osel_mute   = 4'h4;
    localparam logic [3:0] osel_safe   = 4'h5;
    localparam logic [3:0] osel_dump   = 4'h6;
    localparam logic [3:0] osel_fb     = 4'h7;

    localparam logic [1:0] resp_okay   = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

    localparam logic [31:0] zero_word  = 32'h0000_0000;
endpackage

// ===== aisf_sync_if.sv
interface aisf_sync_if;
    logic        locked;
    logic [31:0] period;
    modport link (output locked, output period);
    modport core (input locked, input period);
endinterface

// ===== aisf_link.sv
// measures the digital frame strobe on the link clock; crosses lock and period
module aisf_link #(
    parameter int timeout = 8192
) (
    input  wire logic  link_clk,
    input  wire logic  aclk,
    input  wire logic  aresetn,
    input  wire logic  aclken,
    input  wire logic  frame_pulse,
    aisf_sync_if.link  sync
);
    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] per;
        logic        lock;
        logic        tog;
    } aisf_lk_s;
    aisf_lk_s q;
    aisf_lk_s next_q;
    logic link_rst_n_1;
    logic link_rst_n;
    logic [2:0] tog_s;
    logic [15:0] per_hold;

    always_ff @(posedge link_clk) begin
        link_rst_n_1 <= aresetn;
        link_rst_n   <= link_rst_n_1;
    end

    always_comb begin
        next_q = q;
        if (frame_pulse) begin
            next_q.per  = q.cnt + 16'h0001;
            next_q.cnt  = 16'h0000;
            next_q.lock = 1'b1;
            next_q.tog  = ~q.tog;
        end else if (q.cnt >= 16'(timeout)) begin
            next_q.lock = 1'b0;
        end else begin
            next_q.cnt = q.cnt + 16'h0001;
        end
    end

    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    // period is stable one frame after the toggle, so a toggle handshake is safe
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tog_s    <= 3'h0;
            per_hold <= 16'h0000;
        end else if (aclken) begin
            tog_s <= {tog_s[1:0], q.tog};
            if (tog_s[2] != tog_s[1]) begin
                per_hold <= q.per;
            end
        end
    end

    logic [2:0] lk_s;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lk_s <= 3'h0;
        end else if (aclken) begin
            lk_s <= {lk_s[1:0], q.lock};
        end
    end

    assign sync.locked = lk_s[2] & lk_s[1];
    assign sync.period = {16'h0000, per_hold};
endmodule

// ===== aisf_top.sv
// Functional notes
// - three modes: analog 32k, 48k, digital
// - both outputs carry audio unless the unlock setting mutes them
// - output rate equals selected input rate
// - digital mode rate comes from stream
// - digital selected without signal flags unlock
// - in-line and unlocked flashes display
// - fallback analog switches source to analog
// - fallback rate nearest last digital rate
// - no digital seen means 32k fallback
// - digital outputs run at fallback rate
// - unlock setting mutes all outputs
// - rate select resets to analog 48k
// - input attenuation skips digital; output attenuation everywhere
// - remote outputs follow dump and safe
// - remote inputs act as sneeze, dump
// - seven command inputs, four status outputs
// - each status output selects its condition
// - active output pulls low, else released
module aisf_top #(
    parameter int frame_timeout = 8192,
    parameter int flash_count   = aisf_pkg::flash_cycles
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        aclken,
    input  wire logic        link_clk,
    input  wire logic        frame_pulse,
    input  wire logic [31:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [31:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        dump_button,
    input  wire logic        safe_reached,
    input  wire logic        remote_sneeze_in,
    input  wire logic        remote_dump_in,
    input  wire logic [6:0]  remote_cmd_in,
    output logic             sneeze_cmd,
    output logic             dump_cmd,
    output logic             dump_out,
    output logic             safe_out,
    output logic [6:0]       remote_cmd,
    output logic [3:0]       remote_out_o,
    output logic [3:0]       remote_out_oe_n,
    output logic             use_digital_src,
    output logic             sample_rate_48,
    output logic             audio_mute,
    output logic             display_blank,
    output logic [5:0]       in_atten,
    output logic [5:0]       out_atten,
    output logic             in_atten_bypass_digital
);
    typedef struct packed {
        logic        aw_got;
        logic        w_got;
        logic [7:0]  waddr;
        logic [31:0] wdat;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic [1:0]  sample_rate_select;
        logic        lock_loss_fallback_select;
        logic        inline_mode;
        logic [5:0]  in_att;
        logic [5:0]  out_att;
        logic [15:0] out_sel;
        logic        seen;
        logic        rate_default_high;
        logic [31:0] flash_cnt;
        logic        blank;
        logic        src_dig;
        logic        rate48;
        logic        mute;
        logic        dump_o;
        logic        safe_o;
        logic [3:0]  rout;
        logic [6:0]  rcmd;
        logic        snz;
        logic        dmp;
    } aisf_state_s;

    aisf_state_s q;
    aisf_state_s next_q;
    aisf_sync_if sync ();
    logic [2:0]  s_snz;
    logic [2:0]  s_dmp;
    logic [2:0]  s_dbt;
    logic [2:0]  s_saf;
    logic [2:0]  s_cmd [7];
    logic        dig_sel;
    logic        unlocked;
    logic [31:0] last_hz;
    logic [3:0]  cond;
    logic        wr_fire;
    logic        wr_ok;
    logic        rd_ok;

    aisf_link #(
        .timeout(frame_timeout)
    ) u_link (
        .link_clk   (link_clk),
        .aclk       (aclk),
        .aresetn    (aresetn),
        .aclken     (aclken),
        .frame_pulse(frame_pulse),
        .sync       (sync.link)
    );

    // three-stage input synchronisers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_snz <= 3'h0;
            s_dmp <= 3'h0;
            s_dbt <= 3'h0;
            s_saf <= 3'h0;
        end else if (aclken) begin
            s_snz <= {s_snz[1:0], remote_sneeze_in};
            s_dmp <= {s_dmp[1:0], remote_dump_in};
            s_dbt <= {s_dbt[1:0], dump_button};
            s_saf <= {s_saf[1:0], safe_reached};
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < aisf_pkg::n_rin; gi++) begin : g_rin
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    s_cmd[gi] <= 3'h0;
                end else if (aclken) begin
                    s_cmd[gi] <= {s_cmd[gi][1:0], remote_cmd_in[gi]};
                end
            end
        end
    endgenerate

    assign dig_sel  = q.sample_rate_select == aisf_pkg::rate_sel_dig;
    assign unlocked = dig_sel && !sync.locked;
    // frame period in link cycles of 6 ns converted to hz
    assign last_hz  = (sync.period == aisf_pkg::zero_word) ? aisf_pkg::zero_word
                      : 32'(aisf_pkg::link_hz) / sync.period;
    assign cond     = {unlocked, q.mute, !q.inline_mode, q.seen};

    assign awready = !q.aw_got && !q.bvalid;
    assign wready  = !q.w_got && !q.bvalid;
    assign arready = !q.rvalid;
    assign wr_fire = (q.aw_got || (awvalid && awready)) && (q.w_got || (wvalid && wready));

    always_comb begin
        logic [7:0]  wa;
        logic [31:0] wd;
        logic [7:0]  ra;
        wa = q.aw_got ? q.waddr : awaddr[7:0];
        wd = q.w_got ? q.wdat : wdata;
        ra = araddr[7:0];
        wr_ok = 1'b0;
        rd_ok = 1'b0;
        next_q = q;
        if (awvalid && awready) begin
            next_q.aw_got = 1'b1;
            next_q.waddr  = awaddr[7:0];
        end
        if (wvalid && wready) begin
            next_q.w_got = 1'b1;
            next_q.wdat  = wdata;
        end
        if (wr_fire) begin
            next_q.aw_got = 1'b0;
            next_q.w_got  = 1'b0;
            next_q.bvalid = 1'b1;
            wr_ok = 1'b1;
            if (wa == aisf_pkg::ctrl_ofs) begin
                if (wstrb[0]) begin
                    if (wd[1:0] != 2'h3) begin
                        next_q.sample_rate_select = wd[1:0];
                    end
                    next_q.lock_loss_fallback_select = wd[aisf_pkg::ctrl_fb_bit];
                    next_q.inline_mode = wd[aisf_pkg::ctrl_inline];
                end
                if (wstrb[1]) begin
                    next_q.in_att = wd[13:8];
                end
                if (wstrb[2]) begin
                    next_q.out_att = wd[21:16];
                end
            end else if (wa == aisf_pkg::remote_ofs) begin
                if (wstrb[0]) begin
                    next_q.out_sel[7:0] = wd[7:0];
                end
                if (wstrb[1]) begin
                    next_q.out_sel[15:8] = wd[15:8];
                end
            end else if (wa != aisf_pkg::status_ofs && wa != aisf_pkg::rate_ofs
                         && wa != aisf_pkg::remote_in_ofs) begin
                wr_ok = 1'b0;
            end
            next_q.bresp = wr_ok ? aisf_pkg::resp_okay : aisf_pkg::resp_slverr;
        end else if (q.bvalid && bready) begin
            next_q.bvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_q.rvalid = 1'b1;
            rd_ok = 1'b1;
            unique case (ra)
                aisf_pkg::ctrl_ofs:      next_q.rdata = {10'h000, q.out_att, 2'h0, q.in_att,
                                                         4'h0, q.inline_mode,
                                                         q.lock_loss_fallback_select,
                                                         q.sample_rate_select};
                aisf_pkg::status_ofs:    next_q.rdata = {26'h000_0000, q.rate_default_high, q.seen,
                                                         q.blank, q.mute, unlocked && !q.mute,
                                                         sync.locked};
                aisf_pkg::rate_ofs:      next_q.rdata = last_hz;
                aisf_pkg::remote_ofs:    next_q.rdata = {16'h0000, q.out_sel};
                aisf_pkg::remote_in_ofs: next_q.rdata = {21'h00_0000, q.rout, q.rcmd};
                default: begin
                    next_q.rdata = aisf_pkg::zero_word;
                    rd_ok = 1'b0;
                end
            endcase
            next_q.rresp = rd_ok ? aisf_pkg::resp_okay : aisf_pkg::resp_slverr;
        end else if (q.rvalid && rready) begin
            next_q.rvalid = 1'b0;
        end

        // remember the nearer rate to the last received digital stream
        if (sync.locked && last_hz != aisf_pkg::zero_word) begin
            next_q.seen = 1'b1;
            next_q.rate_default_high = last_hz >= 32'(aisf_pkg::rate_mid_hz);
        end
        // audio routing
        if (!dig_sel) begin
            next_q.src_dig = 1'b0;
            next_q.rate48  = q.sample_rate_select == aisf_pkg::rate_sel_48;
            next_q.mute    = 1'b0;
        end else if (!unlocked) begin
            next_q.src_dig = 1'b1;
            next_q.rate48  = q.rate_default_high;
            next_q.mute    = 1'b0;
        end else if (!q.lock_loss_fallback_select) begin
            next_q.src_dig = 1'b0;
            next_q.rate48  = q.seen && q.rate_default_high;
            next_q.mute    = 1'b0;
        end else begin
            next_q.src_dig = 1'b0;
            next_q.mute    = 1'b1;
        end
        // display flash
        if (unlocked && q.inline_mode) begin
            if (q.flash_cnt >= 32'(flash_count - 1)) begin
                next_q.flash_cnt = aisf_pkg::zero_word;
                next_q.blank = ~q.blank;
            end else begin
                next_q.flash_cnt = q.flash_cnt + 32'h0000_0001;
            end
        end else begin
            next_q.flash_cnt = aisf_pkg::zero_word;
            next_q.blank = 1'b0;
        end
        // remote logic
        next_q.dump_o = s_dbt[2] & s_dbt[1];
        next_q.safe_o = s_saf[2] & s_saf[1];
        next_q.snz    = s_snz[2] & s_snz[1];
        next_q.dmp    = s_dmp[2] & s_dmp[1];
        for (int i = 0; i < aisf_pkg::n_rin; i++) begin
            if (s_cmd[i][2] == s_cmd[i][1]) begin
                next_q.rcmd[i] = s_cmd[i][2];
            end
        end
        for (int j = 0; j < aisf_pkg::n_rout; j++) begin
            unique case (q.out_sel[j*4 +: 4])
                aisf_pkg::osel_on:     next_q.rout[j] = 1'b1;
                aisf_pkg::osel_bypass: next_q.rout[j] = !q.inline_mode;
                aisf_pkg::osel_unlock: next_q.rout[j] = unlocked;
                aisf_pkg::osel_mute:   next_q.rout[j] = q.mute;
                aisf_pkg::osel_safe:   next_q.rout[j] = q.safe_o;
                aisf_pkg::osel_dump:   next_q.rout[j] = q.dump_o;
                aisf_pkg::osel_fb:     next_q.rout[j] = unlocked && !q.lock_loss_fallback_select;
                default:               next_q.rout[j] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.sample_rate_select <= aisf_pkg::rate_sel_rst;
            q.rate48 <= 1'b1;
        end else if (aclken) begin
            q <= next_q;
        end
    end

    assign bvalid  = q.bvalid;
    assign bresp   = q.bresp;
    assign rvalid  = q.rvalid;
    assign rresp   = q.rresp;
    assign rdata   = q.rdata;
    assign use_digital_src = q.src_dig;
    assign sample_rate_48  = q.rate48;
    assign audio_mute      = q.mute;
    assign display_blank   = q.blank;
    assign in_atten        = q.in_att;
    assign out_atten       = q.out_att;
    assign in_atten_bypass_digital = q.src_dig;
    assign dump_out   = q.dump_o;
    assign safe_out   = q.safe_o;
    assign sneeze_cmd = q.snz;
    assign dump_cmd   = q.dmp;
    assign remote_cmd = q.rcmd;
    assign remote_out_o    = 4'h0;
    assign remote_out_oe_n = ~q.rout;

    // assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_unl_fb;
        aclken && unlocked && !q.lock_loss_fallback_select;
    endsequence

    rate_reset_a: assert property ($rose(aresetn) |-> q.sample_rate_select == aisf_pkg::rate_sel_48)
        else $error("rate select not 48k after reset");
    unlock_out_a: assert property (aclken && unlocked && q.out_sel[aisf_pkg::osel_w-1:0] == aisf_pkg::osel_unlock
                                   |=> !remote_out_oe_n[0])
        else $error("unlock not signalled on remote output");
    fb_src_a: assert property (s_unl_fb ##1 aclken |-> !q.src_dig && !q.mute)
        else $error("fallback did not select analog");
    fb_nosig_a: assert property ((s_unl_fb and !q.seen) ##1 aclken |-> !q.rate48)
        else $error("fallback not 32k without digital");
    mute_unl_a: assert property (aclken && unlocked && q.lock_loss_fallback_select |=> aclken |-> q.mute)
        else $error("mute missing on lock loss");
    relock_a: assert property (aclken && dig_sel && sync.locked |=> aclken |-> q.src_dig && !q.mute)
        else $error("relock did not restore digital");
    analog_rate_a: assert property (aclken && !dig_sel |=> aclken |-> q.rate48 == $past(q.sample_rate_select[0]))
        else $error("analog rate mismatch");
    flash_idle_a: assert property (aclken && !(unlocked && q.inline_mode) |=> !q.blank)
        else $error("display blank while not flashing");
    rout_drive_a: assert property (aclken && q.out_sel[aisf_pkg::osel_w-1:0] == aisf_pkg::osel_on
                                   |=> !remote_out_oe_n[0])
        else $error("remote output drive wrong");
endmodule

// ===== aisf_src.sv
module aisf_src (
    input  wire logic        link_clk,
    input  wire logic        run,
    input  wire logic [15:0] period,
    output logic             frame_pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] cnt = 16'h0000;
    initial frame_pulse = 1'b0;
    // one link-cycle strobe per frame, silent when stopped
    always @(posedge link_clk) begin
        cnt <= (!run || cnt == period - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
        frame_pulse <= run && (cnt == period - 16'h0001);
    end
endmodule

// ===== aisf_top_tb.sv
module aisf_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk = 0, link_clk = 0, aresetn = 0, src_run = 0;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [3:0] wstrb = 4'hf;
    logic dump_button = 0, safe_reached = 0, remote_sneeze_in = 0, remote_dump_in = 0;
    logic [6:0] remote_cmd_in = 0;
    logic awready, wready, bvalid, arready, rvalid, frame_pulse;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic sneeze_cmd, dump_cmd, dump_out, safe_out, use_digital_src, sample_rate_48, audio_mute, display_blank;
    logic [6:0] remote_cmd;
    logic [3:0] remote_out_o, remote_out_oe_n;
    logic [5:0] in_atten, out_atten;
    logic in_atten_bypass_digital;
    int num_errors = 0, cmp_count = 0;
    logic [31:0] d;
    logic [1:0] r;
    initial forever #10 aclk = ~aclk;
    // link clock runs free: lock loss is timed on it
    initial begin #1.3; forever #3 link_clk = ~link_clk; end
    aisf_src SRC (.link_clk(link_clk), .run(src_run), .period(16'd3472), .frame_pulse(frame_pulse));
    aisf_top #(.frame_timeout(8192), .flash_count(4)) DUT (
        .aclk(aclk), .aresetn(aresetn), .aclken(1'b1), .link_clk(link_clk), .frame_pulse(frame_pulse),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .dump_button(dump_button), .safe_reached(safe_reached),
        .remote_sneeze_in(remote_sneeze_in), .remote_dump_in(remote_dump_in), .remote_cmd_in(remote_cmd_in),
        .sneeze_cmd(sneeze_cmd), .dump_cmd(dump_cmd), .dump_out(dump_out), .safe_out(safe_out),
        .remote_cmd(remote_cmd), .remote_out_o(remote_out_o), .remote_out_oe_n(remote_out_oe_n),
        .use_digital_src(use_digital_src), .sample_rate_48(sample_rate_48), .audio_mute(audio_mute),
        .display_blank(display_blank), .in_atten(in_atten), .out_atten(out_atten),
        .in_atten_bypass_digital(in_atten_bypass_digital));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic hang();
        num_errors++;
        $display("[ERR] wait expired");
        final_report();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n = 0;
        logic a_rdy, w_rdy, b_v;
        awaddr <= {24'h0000_00, a}; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
        // handshakes judged on values settled before the rising edge
        do begin
            @(negedge aclk); a_rdy = awready; w_rdy = wready; b_v = bvalid;
            @(posedge aclk); n++;
            if (a_rdy) awvalid <= 0;
            if (w_rdy) wvalid <= 0;
        end while (!b_v && n < 200);
        bready <= 0;
        if (n >= 200) hang();
        repeat (3) @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        int n = 0;
        logic a_rdy, r_v;
        araddr <= {24'h0000_00, a}; arvalid <= 1; rready <= 1;
        do begin
            @(negedge aclk); a_rdy = arready; r_v = rvalid; v = rdata; rs = rresp;
            @(posedge aclk); n++;
            if (a_rdy) arvalid <= 0;
        end while (!r_v && n < 200);
        rready <= 0;
        if (n >= 200) hang();
        @(posedge aclk);
    endtask
    task automatic wait_st(input int b, input logic v);
        int n = 0;
        do begin rd(aisf_pkg::status_ofs, d, r); n++; end while (d[b] !== v && n < 3000);
        if (n >= 3000) hang();
        repeat (3) @(posedge aclk);
    endtask
    task automatic flashes(output int t);
        logic p;
        t = 0; p = display_blank;
        repeat (40) begin @(posedge aclk); #1; if (display_blank !== p) t++; p = display_blank; end
    endtask
    task automatic t_reset();
        rd(aisf_pkg::ctrl_ofs, d, r);
        chk("rate_sel", {30'h0, aisf_pkg::rate_sel_48}, {30'h0, d[1:0]});
        chk("rate48", 1, sample_rate_48);
        chk("oe_n", 4'hf, remote_out_oe_n);
        rd(8'h20, d, r);
        chk("unmapped_resp", {30'h0, aisf_pkg::resp_slverr}, {30'h0, r});
        chk("unmapped_data", 32'h0000_0000, d);
        $display("test reset done");
    endtask
    task automatic t_modes();
        for (int i = 0; i < 2; i++) begin
            wr(aisf_pkg::ctrl_ofs, i);
            chk("rate48", i, sample_rate_48);
            chk("digital", 0, use_digital_src);
            chk("outputs", 0, audio_mute);
        end
        $display("test modes done");
    endtask
    task automatic t_unlock();
        int t;
        wr(aisf_pkg::ctrl_ofs, 32'h0000_000a);
        wait_st(aisf_pkg::status_fb, 1);
        chk("locked", 0, d[aisf_pkg::status_lock]);
        chk("digital", 0, use_digital_src);
        chk("rate48", 0, sample_rate_48);
        flashes(t);
        chk("flashing", 1, t > 0);
        wr(aisf_pkg::ctrl_ofs, 32'h0000_0006);
        wait_st(aisf_pkg::status_mute, 1);
        chk("mute", 1, audio_mute);
        flashes(t);
        chk("bypass_flash", 0, t);
        wr(aisf_pkg::remote_ofs, 32'h0000_7432);
        chk("oe_n_modes", 4'b1000, remote_out_oe_n);
        rd(aisf_pkg::remote_in_ofs, d, r);
        chk("remote_in", 32'h0000_0380, d);
        $display("test unlock done");
    endtask
    task automatic t_lock();
        src_run <= 1;
        wait_st(aisf_pkg::status_lock, 1);
        chk("digital", 1, use_digital_src);
        chk("mute", 0, audio_mute);
        chk("att_skip", 1, in_atten_bypass_digital);
        // let a few full frames pass so the measured period settles
        repeat (2500) @(posedge aclk);
        rd(aisf_pkg::status_ofs, d, r);
        chk("near48", 1, d[aisf_pkg::status_hi]);
        chk("seen", 1, d[aisf_pkg::status_seen]);
        chk("rate48", 1, sample_rate_48);
        wr(aisf_pkg::ctrl_ofs, 32'h0000_0002);
        src_run <= 0;
        wait_st(aisf_pkg::status_fb, 1);
        chk("digital", 0, use_digital_src);
        chk("rate48", 1, sample_rate_48);
        chk("mute", 0, audio_mute);
        $display("test lock done");
    endtask
    task automatic t_remote();
        dump_button <= 1; remote_sneeze_in <= 1; remote_cmd_in <= 7'h55;
        wr(aisf_pkg::remote_ofs, 32'h0000_5601);
        repeat (8) @(posedge aclk);
        chk("dump_safe", 2'b10, {dump_out, safe_out});
        chk("sneeze_dump", 2'b10, {sneeze_cmd, dump_cmd});
        chk("cmd", 7'h55, remote_cmd);
        chk("oe_n", 4'b1010, remote_out_oe_n);
        chk("out_lvl", 4'h0, remote_out_o);
        dump_button <= 0; safe_reached <= 1; remote_dump_in <= 1; remote_sneeze_in <= 0; remote_cmd_in <= 7'h2a;
        repeat (8) @(posedge aclk);
        chk("dump_safe", 2'b01, {dump_out, safe_out});
        chk("sneeze_dump", 2'b01, {sneeze_cmd, dump_cmd});
        chk("cmd", 7'h2a, remote_cmd);
        chk("oe_n", 4'b0110, remote_out_oe_n);
        $display("test remote done");
    endtask
    task automatic t_atten();
        wr(aisf_pkg::ctrl_ofs, 32'h002a_1501);
        chk("in_att", 6'h15, in_atten);
        chk("out_att", 6'h2a, out_atten);
        chk("att_skip", 0, in_atten_bypass_digital);
        $display("test atten done");
    endtask
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        t_reset();
        t_modes();
        t_unlock();
        t_lock();
        t_remote();
        t_atten();
        final_report();
    end
endmodule
